// ### rtl/smm_pkg.sv
`default_nettype none
package smm_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_DELAY_LOW = 8'h34;
   localparam logic [7:0] OFS_DELAY_HIGH = 8'h35;
   localparam logic [7:0] OFS_PULSE_COUNT = 8'h36;
   localparam logic [7:0] OFS_PHASE_LOW = 8'h37;
   localparam logic [7:0] OFS_PHASE_HIGH = 8'h38;
   localparam logic [7:0] OFS_JITTER_TOL = 8'h39;
   localparam logic [7:0] OFS_ALIGN_CTRL = 8'h3A;

   // field widths and positions
   localparam int DELAY_W = 12;
   localparam int PHASE_W = 12;
   localparam int COUNT_W = 8;
   localparam int TOL_W = 6;
   localparam int TOL_IGNORED_LSBS = 2;
   localparam int DELAY_ZERO_LSBS = 2;
   localparam int FRAMES_W = 5;
   localparam int HIGH_FIELD_LSB = 8;
   localparam int HIGH_FIELD_W = 4;

   // reset values
   localparam logic [TOL_W-1:0] TOL_RESET = 6'h00;
   localparam logic [DELAY_W-1:0] DELAY_RESET = 12'h000;
   localparam logic [PHASE_W-1:0] PHASE_RESET = 12'h000;
   localparam logic [COUNT_W-1:0] COUNT_RESET = 8'h00;

   // synchronization modes, in field order 0, 1, 2
   typedef enum logic [1:0] {
      SMM_MODE_MONITOR,
      SMM_MODE_CONTINUOUS,
      SMM_MODE_ONESHOT,
      SMM_MODE_SPARE
   } smm_mode_t;
endpackage
`default_nettype wire

// ### rtl/smm_lmfc_if.sv
`timescale 1ns/1ps
`default_nettype none
interface smm_lmfc_if;
   logic align_req;
   logic [11:0] target_clks;
   logic [4:0] target_frms;
   logic lmfc_rise;
   logic lmfc_level;
   modport gen (
      input align_req,
      input target_clks,
      input target_frms,
      output lmfc_rise,
      output lmfc_level
   );
   modport ctl (
      output align_req,
      output target_clks,
      output target_frms,
      input lmfc_rise,
      input lmfc_level
   );
endinterface
`default_nettype wire

// ### rtl/smm_lmfc_gen.sv
`timescale 1ns/1ps
`default_nettype none
module smm_lmfc_gen #(
   parameter int LMFC_CLKS = 128,
   parameter int FRAME_CLKS = 4
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   smm_lmfc_if.gen lnk
);
   localparam int PH_W = $clog2(LMFC_CLKS);
   localparam int WAIT_W = 18;

   logic [PH_W-1:0] phase, next_phase;
   logic [WAIT_W-1:0] wait_cnt, next_wait_cnt;
   logic waiting, next_waiting;
   logic rise, next_rise;
   logic level, next_level;
   logic [WAIT_W-1:0] target_total;

   // target in dac clocks: clock part plus whole frames
   assign target_total = WAIT_W'(lnk.target_clks) + WAIT_W'(lnk.target_frms) * WAIT_W'(FRAME_CLKS);

   // free-running multiframe phase, restarted when the alignment countdown expires
   always_comb begin
      next_phase = (phase == PH_W'(LMFC_CLKS - 1)) ? '0 : phase + 1'b1;
      next_wait_cnt = wait_cnt;
      next_waiting = waiting;
      if (lnk.align_req) begin
         next_waiting = 1'b1;
         next_wait_cnt = target_total;
      end else if (waiting) begin
         if (wait_cnt == '0) begin
            next_waiting = 1'b0;
            next_phase = '0;
         end else begin
            next_wait_cnt = wait_cnt - 1'b1;
         end
      end
      next_rise = (next_phase == '0);
      next_level = (next_phase < PH_W'(LMFC_CLKS / 2));
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         phase <= '0;
         wait_cnt <= '0;
         waiting <= 1'b0;
         rise <= 1'b0;
         level <= 1'b0;
      end else if (ce) begin
         phase <= next_phase;
         wait_cnt <= next_wait_cnt;
         waiting <= next_waiting;
         rise <= next_rise;
         level <= next_level;
      end
   end

   assign lnk.lmfc_rise = rise;
   assign lnk.lmfc_level = level;

   // expired countdown places the multiframe edge on the very next cycle
   a_align_edge_lands: assert property (@(posedge clk) disable iff (!rst_n)
      ce && waiting && wait_cnt == '0 && !lnk.align_req |=> rise)
      else $error("multiframe edge missing after alignment countdown");
endmodule
`default_nettype wire

// ### rtl/smm_sync_monitor.sv
// Summary of operation
// - measure reference-to-multiframe edge delay in clocks, 12 bits over two registers
// - two lowest bits of the reported delay always read zero
// - a write to delay or phase registers freezes delay, count, phase for reading
// - keep an 8-bit count of reference pulses, readable
// - any write to the pulse count register clears the count
// - capture reference event phase as 12-bit thermometer code, two registers
// - 6-bit jitter tolerance in clocks, lowest two bits ignored
// - timing variation beyond tolerance raises the jitter condition
// - monitor mode only measures, never realigns the multiframe clock
// - continuous mode realigns on every reference pulse
// - one-shot mode realigns on next pulse, then falls back to monitor
// - alignment puts multiframe edge at target clocks plus frames after reference
// - jitter sets sticky flag bit 4, cleared by writing one
// - jitter reaches interrupt output only when enable bit 4 is one
`timescale 1ns/1ps
`default_nettype none
module smm_sync_monitor #(
   parameter int LMFC_CLKS = 128,
   parameter int FRAME_CLKS = 4
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic ref_in,
   input wire logic [smm_pkg::PHASE_W-1:0] ref_phase_in,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic [smm_pkg::DELAY_W-1:0] target_align_delay_clocks,
   input wire logic [smm_pkg::FRAMES_W-1:0] target_align_delay_frames,
   input wire logic ref_jitter_irq_enable,
   input wire logic ref_jitter_flag_clear,
   output logic ref_jitter_flag,
   output logic jitter_irq,
   output logic lmfc_out
);
   import smm_pkg::*;

   smm_lmfc_if lnk ();

   // address match helper, shared by write strobes and readback
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   logic ref_d, ref_rise;
   logic [COUNT_W-1:0] live_count, next_live_count;
   logic [PHASE_W-1:0] live_phase, next_live_phase;
   logic [DELAY_W-1:0] meas_cnt, next_meas_cnt;
   logic meas_run, next_meas_run;
   logic [DELAY_W-1:0] meas_delay, next_meas_delay;
   logic [DELAY_W-1:0] prev_delay, next_prev_delay;
   logic have_prev, next_have_prev;
   logic meas_done;
   logic [DELAY_W-1:0] done_delay, jit_diff, tol_masked;
   logic jit_event;
   logic [DELAY_W-1:0] snap_delay, next_snap_delay;
   logic [PHASE_W-1:0] snap_phase, next_snap_phase;
   logic [COUNT_W-1:0] snap_count, next_snap_count;
   logic [TOL_W-1:0] tol, next_tol;
   smm_mode_t mode, next_mode;
   logic next_flag, next_irq, lmfc_q;
   logic [7:0] next_rdata;
   logic wr_snap, wr_count, wr_tol, wr_ctrl, align_req;

   // write strobes
   assign wr_snap = reg_wr && (hit(reg_addr, OFS_DELAY_LOW) || hit(reg_addr, OFS_DELAY_HIGH)
                    || hit(reg_addr, OFS_PHASE_LOW) || hit(reg_addr, OFS_PHASE_HIGH));
   assign wr_count = reg_wr && hit(reg_addr, OFS_PULSE_COUNT);
   assign wr_tol = reg_wr && hit(reg_addr, OFS_JITTER_TOL);
   assign wr_ctrl = reg_wr && hit(reg_addr, OFS_ALIGN_CTRL);
   assign ref_rise = ref_in && !ref_d;

   // alignment request per mode; spare code behaves as monitor
   always_comb begin
      align_req = 1'b0;
      case (mode)
         SMM_MODE_MONITOR: align_req = 1'b0;
         SMM_MODE_CONTINUOUS: align_req = ref_rise;
         SMM_MODE_ONESHOT: align_req = ref_rise;
         default: align_req = 1'b0;
      endcase
   end

   assign lnk.align_req = align_req;
   assign lnk.target_clks = target_align_delay_clocks;
   assign lnk.target_frms = target_align_delay_frames;

   smm_lmfc_gen #(
      .LMFC_CLKS(LMFC_CLKS),
      .FRAME_CLKS(FRAME_CLKS)
   ) u_gen (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .lnk(lnk)
   );

   // delay measurement: count from reference edge to next multiframe edge
   always_comb begin
      next_meas_cnt = meas_cnt;
      next_meas_run = meas_run;
      meas_done = 1'b0;
      done_delay = meas_cnt;
      if (ref_rise && lnk.lmfc_rise) begin
         meas_done = 1'b1;
         done_delay = '0;
         next_meas_run = 1'b0;
      end else if (ref_rise) begin
         next_meas_run = 1'b1;
         next_meas_cnt = DELAY_W'(1);
      end else if (meas_run && lnk.lmfc_rise) begin
         meas_done = 1'b1;
         next_meas_run = 1'b0;
      end else if (meas_run && meas_cnt != '1) begin
         next_meas_cnt = meas_cnt + 1'b1;  // saturates, never wraps
      end
      done_delay[DELAY_ZERO_LSBS-1:0] = '0;
      next_meas_delay = meas_done ? done_delay : meas_delay;
      next_prev_delay = meas_done ? done_delay : prev_delay;
      next_have_prev = have_prev || meas_done;
   end

   // tolerance with its low bits masked
   assign tol_masked = DELAY_W'({tol[TOL_W-1:TOL_IGNORED_LSBS], TOL_IGNORED_LSBS'(0)});
   assign jit_diff = (done_delay >= prev_delay) ? done_delay - prev_delay : prev_delay - done_delay;
   assign jit_event = meas_done && have_prev && (jit_diff > tol_masked);

   // pulse count, phase capture, snapshot and control registers
   always_comb begin
      next_live_count = live_count;
      if (wr_count) begin
         next_live_count = ref_rise ? COUNT_W'(1) : COUNT_RESET;
      end else if (ref_rise) begin
         next_live_count = live_count + 1'b1;
      end
      next_live_phase = ref_rise ? ref_phase_in : live_phase;
      next_snap_delay = wr_snap ? meas_delay : snap_delay;
      next_snap_phase = wr_snap ? live_phase : snap_phase;
      next_snap_count = wr_snap ? live_count : snap_count;
      next_tol = wr_tol ? reg_wdata[TOL_W-1:0] : tol;
      next_mode = mode;
      // software write beats the one-shot fallback in the same cycle
      if (wr_ctrl) begin
         next_mode = smm_mode_t'(reg_wdata[1:0]);
      end else if (mode == SMM_MODE_ONESHOT && ref_rise) begin
         next_mode = SMM_MODE_MONITOR;
      end
      // sticky flag, a same-cycle event beats the clear
      next_flag = jit_event || (ref_jitter_flag && !ref_jitter_flag_clear);
      next_irq = next_flag && ref_jitter_irq_enable;
   end

   // readback mux; reserved bits read zero, unmapped addresses read zero
   always_comb begin
      next_rdata = 8'h00;
      if (hit(reg_addr, OFS_DELAY_LOW)) begin
         next_rdata = snap_delay[7:0];
      end else if (hit(reg_addr, OFS_DELAY_HIGH)) begin
         next_rdata = {4'h0, snap_delay[HIGH_FIELD_LSB +: HIGH_FIELD_W]};
      end else if (hit(reg_addr, OFS_PULSE_COUNT)) begin
         next_rdata = snap_count;
      end else if (hit(reg_addr, OFS_PHASE_LOW)) begin
         next_rdata = snap_phase[7:0];
      end else if (hit(reg_addr, OFS_PHASE_HIGH)) begin
         next_rdata = {4'h0, snap_phase[HIGH_FIELD_LSB +: HIGH_FIELD_W]};
      end else if (hit(reg_addr, OFS_JITTER_TOL)) begin
         next_rdata = {2'h0, tol};
      end else if (hit(reg_addr, OFS_ALIGN_CTRL)) begin
         next_rdata = {6'h00, mode};
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ref_d <= 1'b0;
         live_count <= COUNT_RESET;
         live_phase <= PHASE_RESET;
         meas_cnt <= DELAY_RESET;
         meas_run <= 1'b0;
         meas_delay <= DELAY_RESET;
         prev_delay <= DELAY_RESET;
         have_prev <= 1'b0;
         snap_delay <= DELAY_RESET;
         snap_phase <= PHASE_RESET;
         snap_count <= COUNT_RESET;
         tol <= TOL_RESET;
         mode <= SMM_MODE_MONITOR;
         ref_jitter_flag <= 1'b0;
         jitter_irq <= 1'b0;
         reg_rdata <= 8'h00;
         lmfc_q <= 1'b0;
      end else if (ce) begin
         ref_d <= ref_in;
         live_count <= next_live_count;
         live_phase <= next_live_phase;
         meas_cnt <= next_meas_cnt;
         meas_run <= next_meas_run;
         meas_delay <= next_meas_delay;
         prev_delay <= next_prev_delay;
         have_prev <= next_have_prev;
         snap_delay <= next_snap_delay;
         snap_phase <= next_snap_phase;
         snap_count <= next_snap_count;
         tol <= next_tol;
         mode <= next_mode;
         ref_jitter_flag <= next_flag;
         jitter_irq <= next_irq;
         reg_rdata <= next_rdata;
         lmfc_q <= lnk.lmfc_level;
      end
   end

   // registered copy keeps the pin glitch-free
   assign lmfc_out = lmfc_q;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_pulse_taken;
      ce && ref_rise && !wr_count;
   endsequence
   sequence s_snap_write;
      ce && wr_snap;
   endsequence
   sequence s_jitter_seen;
      ce && jit_event;
   endsequence

   a_delay_lsbs_zero: assert property (meas_delay[1:0] == 2'h0)
      else $error("delay low bits not zero");
   a_capture_delay: assert property (ce && meas_run && lnk.lmfc_rise && !ref_rise
      |=> meas_delay == ($past(meas_cnt) & 12'hFFC))
      else $error("delay not captured at multiframe edge");
   a_snap_freeze: assert property (s_snap_write |=> snap_delay == $past(meas_delay)
      && snap_count == $past(live_count) && snap_phase == $past(live_phase))
      else $error("snapshot not taken on write");
   a_count_step: assert property (s_pulse_taken |=> live_count == $past(live_count) + 8'h01)
      else $error("pulse count did not step");
   a_count_clear: assert property (ce && wr_count && !ref_rise |=> live_count == 8'h00)
      else $error("pulse count not cleared by write");
   a_phase_take: assert property (ce && ref_rise |=> live_phase == $past(ref_phase_in))
      else $error("reference phase not captured");
   a_jitter_sets: assert property (s_jitter_seen |=> ref_jitter_flag ##0 ref_jitter_flag)
      else $error("jitter event did not set flag");
   a_flag_clears: assert property (ce && ref_jitter_flag_clear && !jit_event |=> !ref_jitter_flag)
      else $error("jitter flag not cleared");
   a_irq_gated: assert property (ce && !ref_jitter_irq_enable |=> !jitter_irq)
      else $error("interrupt raised while disabled");
   a_monitor_still: assert property (mode == SMM_MODE_MONITOR |-> !align_req)
      else $error("alignment requested in monitor mode");
   a_cont_aligns: assert property (mode == SMM_MODE_CONTINUOUS && ref_rise |-> align_req)
      else $error("continuous mode missed an alignment");
   a_oneshot_back: assert property (ce && mode == SMM_MODE_ONESHOT && ref_rise && !wr_ctrl
      |-> align_req ##1 mode == SMM_MODE_MONITOR)
      else $error("one-shot mode did not fall back");
   a_tol_masked: assert property (ce && meas_done && have_prev && jit_diff <= {6'h00, tol[5:2], 2'h0}
      |-> !jit_event)
      else $error("jitter raised within tolerance");

   // readback paths and snapshot hold
   a_snap_hold: assert property (ce && !wr_snap |=> $stable(snap_delay)
      && $stable(snap_count) && $stable(snap_phase))
      else $error("snapshot changed without a write");
   a_count_readback: assert property (ce && hit(reg_addr, OFS_PULSE_COUNT)
      |=> reg_rdata == $past(snap_count))
      else $error("pulse count readback wrong");
   a_reserved_zero: assert property (ce && (hit(reg_addr, OFS_DELAY_HIGH)
      || hit(reg_addr, OFS_PHASE_HIGH)) |=> reg_rdata[7:4] == 4'h0)
      else $error("reserved readback bits not zero");
   a_tol_readback: assert property (ce && hit(reg_addr, OFS_JITTER_TOL)
      |=> reg_rdata == {2'h0, $past(tol)})
      else $error("tolerance readback wrong");
   a_mode_readback: assert property (ce && hit(reg_addr, OFS_ALIGN_CTRL)
      |=> reg_rdata == {6'h00, $past(mode)})
      else $error("mode readback wrong");

   // sticky flag, gated interrupt and count wrap
   a_flag_sticky: assert property (ce && ref_jitter_flag && !ref_jitter_flag_clear
      |=> ref_jitter_flag)
      else $error("jitter flag lost before clear");
   a_irq_follows: assert property (ce && ref_jitter_irq_enable && ref_jitter_flag
      && !ref_jitter_flag_clear |=> jitter_irq)
      else $error("enabled interrupt not raised");
   a_count_wraps: assert property (ce && ref_rise && !wr_count && live_count == 8'hFF
      |=> live_count == 8'h00)
      else $error("pulse count did not wrap");
endmodule
`default_nettype wire

// ### dv/smm_ref_src.sv
`timescale 1ns/1ps
`default_nettype none
module smm_ref_src (
   input wire logic clk,
   output logic ref_in,
   output logic [11:0] ref_phase_in
);
   initial begin
      ref_in = 1'b0;
      ref_phase_in = 12'h000;
   end

   // one pulse of w cycles; caller sits just after a falling edge
   task automatic pulse(input int w, input logic [11:0] ph);
      ref_in = 1'b1;
      ref_phase_in = ph;
      repeat (w) @(negedge clk);
      ref_in = 1'b0;
      // phase lines mean nothing between events, so show a changed pattern
      ref_phase_in = ~ph;
      // at least one low cycle before the next event
      @(negedge clk);
   endtask
endmodule
`default_nettype wire

// ### dv/sysref_lmfc_sync_monitor_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin \
   n_tests++; \
   if ((g) !== (e)) begin \
      num_errors++; \
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); \
   end \
end
module sysref_lmfc_sync_monitor_test;
   import smm_pkg::*;
   localparam int LMFC = 16;
   localparam int FRM = 2;
   typedef struct {int e; logic [1:0] s; logic [7:0] v;} smm_note_t;
   logic clk, rst_n, ce, reg_wr, irq_en, flag_clr, ref_in, flag, irq, lmfc_out;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, got;
   logic [DELAY_W-1:0] tclk;
   logic [FRAMES_W-1:0] tfrm;
   logic [PHASE_W-1:0] phase, ph;
   logic [31:0] lf = 32'h17EC;
   smm_note_t notes[$];
   int num_errors = 0, n_tests = 0, cyc = 0, base = 0, t0 = 0;

   smm_sync_monitor #(.LMFC_CLKS(LMFC), .FRAME_CLKS(FRM)) dut (
      .clk(clk), .rst_n(rst_n), .ce(ce), .ref_in(ref_in), .ref_phase_in(phase),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .target_align_delay_clocks(tclk), .target_align_delay_frames(tfrm),
      .ref_jitter_irq_enable(irq_en), .ref_jitter_flag_clear(flag_clr),
      .ref_jitter_flag(flag), .jitter_irq(irq), .lmfc_out(lmfc_out));
   smm_ref_src src (.clk(clk), .ref_in(ref_in), .ref_phase_in(phase));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // edge counter; every note names the edge after which it is due
   always @(posedge clk) cyc <= cyc + 1;

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // watcher: takes due notes off the queue in order and compares
   always @(negedge clk) begin
      while (notes.size() > 0 && notes[0].e == cyc) begin
         case (notes[0].s)
            2'h0: got = reg_rdata;
            2'h1: got = {7'h00, lmfc_out};
            2'h2: got = {7'h00, flag};
            default: got = {7'h00, irq};
         endcase
         `CHK(got, notes[0].v)
         void'(notes.pop_front());
      end
   end

   function automatic void at(input int e, input logic [1:0] s, input logic [7:0] v);
      notes.push_back('{e, s, v});
   endfunction

   task automatic rd(input logic [7:0] a, input logic [7:0] v);
      reg_addr = a;
      at(cyc + 1, 2'h0, v);
      @(negedge clk);
   endtask

   // write, then one idle cycle so a snapshot has settled
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
      @(negedge clk);
   endtask

   task automatic clr;
      flag_clr = 1'b1;
      @(negedge clk);
      flag_clr = 1'b0;
   endtask

   // fire one pulse whose sampled edge sits at off past a multiframe start
   task automatic fire(input int off);
      while (((cyc + 1 - base - off) % LMFC + LMFC) % LMFC != 0) @(negedge clk);
      t0 = cyc + 1;
      ph = 12'hFFF >> (lf % 13);
      lf = lfsr(lf);
      src.pulse(1, ph);
   endtask

   // the new start falls half a multiframe off the old one, so a missed or
   // unwanted realign flips every sample; samples skip the edges of a window
   task automatic sync(input logic [11:0] tc, input logic re);
      int s;
      tclk = tc;
      fire(8 - int'(tc) - 3 * FRM - 2);
      s = t0 + int'(tc) + 3 * FRM + 2;
      at(s + 1, 2'h1, {7'h00, re});
      at(s + 6, 2'h1, {7'h00, re});
      at(s + 9, 2'h1, {7'h00, !re});
      at(s + 14, 2'h1, {7'h00, !re});
      if (re) base = s;
      while (cyc < s + 16) @(negedge clk);
   endtask

   // delays two above a multiple of four read the same under a one-cycle skew
   task automatic meas(input int d);
      fire(-d);
      repeat (20) @(negedge clk);
   endtask

   task automatic wrap_up;
      if (notes.size() != 0) num_errors++;
      $display("comparisons=%0d mismatches=%0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   initial begin
      rst_n = 1'b0;
      ce = 1'b1;
      reg_wr = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      tclk = 12'h000;
      tfrm = 5'h03;
      irq_en = 1'b0;
      flag_clr = 1'b0;
      ph = 12'h000;
      repeat (12) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      for (int a = 8'h34; a <= 8'h3B; a++) rd(a[7:0], 8'h00);
      wr(OFS_JITTER_TOL, 8'hFF);
      rd(OFS_JITTER_TOL, 8'h3F);
      wr(OFS_ALIGN_CTRL, 8'hFE);
      rd(OFS_ALIGN_CTRL, 8'h02);
      // random widths and phases; 257 events wrap the count to one
      repeat (257) begin
         ph = 12'hFFF >> (lf % 13);
         src.pulse(1 + int'(lf % 3), ph);
         lf = lfsr(lf);
      end
      rd(OFS_ALIGN_CTRL, 8'h00);
      wr(OFS_PHASE_HIGH, lf[7:0]);
      rd(OFS_PULSE_COUNT, 8'h01);
      rd(OFS_PHASE_LOW, ph[7:0]);
      rd(OFS_PHASE_HIGH, {4'h0, ph[11:8]});
      src.pulse(2, ph);
      rd(OFS_PULSE_COUNT, 8'h01);
      wr(OFS_PULSE_COUNT, lf[15:8]);
      src.pulse(1, ph);
      src.pulse(1, ph);
      // frozen clock enable: a pulse and a clear are both ignored
      ce = 1'b0;
      src.pulse(1, ph);
      wr(OFS_PULSE_COUNT, 8'h00);
      ce = 1'b1;
      wr(OFS_DELAY_LOW, lf[23:16]);
      rd(OFS_PULSE_COUNT, 8'h02);
      wr(OFS_ALIGN_CTRL, 8'h01);
      sync(12'h004 + {9'h000, lf[2:0]}, 1'b1);
      sync(12'h005 + {9'h000, lf[4:2]}, 1'b1);
      wr(OFS_ALIGN_CTRL, 8'h02);
      sync(12'h006, 1'b1);
      sync(12'h009, 1'b0);
      rd(OFS_ALIGN_CTRL, 8'h00);
      // monitor and the spare code leave the multiframe alone
      for (int m = 0; m < 4; m += 3) begin
         wr(OFS_ALIGN_CTRL, m[7:0]);
         sync(12'h007, 1'b0);
      end
      meas(10);
      wr(OFS_DELAY_HIGH, 8'h00);
      rd(OFS_DELAY_LOW, 8'h08);
      rd(OFS_DELAY_HIGH, 8'h00);
      wr(OFS_JITTER_TOL, 8'h07);
      clr();
      at(cyc + 1, 2'h2, 8'h00);
      meas(14);
      at(cyc + 1, 2'h2, 8'h00);
      meas(6);
      at(cyc + 1, 2'h2, 8'h01);
      at(cyc + 1, 2'h3, 8'h00);
      @(negedge clk);
      irq_en = 1'b1;
      at(cyc + 2, 2'h3, 8'h01);
      repeat (2) @(negedge clk);
      clr();
      at(cyc + 1, 2'h2, 8'h00);
      at(cyc + 1, 2'h3, 8'h00);
      repeat (4) @(negedge clk);
      wrap_up();
   end

   // watchdog well past the under two thousand cycles the run needs
   initial begin
      #100000;
      num_errors++;
      wrap_up();
   end
endmodule
`default_nettype wire
